//--- pkg/fwd_pkg.sv
`default_nettype none
package fwd_pkg;
  localparam int ADDR_W = 24;
  localparam int PADDR_W = 12;
  // register indices; byte address is four times the index
  localparam logic [7:0] CEIL_IDX = 8'h69;
  localparam logic [7:0] XCTL_IDX = 8'h70;
  localparam logic [7:0] STAT_IDX = 8'h71;
  localparam logic [7:0] CEIL_RESET = 8'h02;
  localparam logic [7:0] CEIL_WMASK = 8'hfe;
  localparam logic [7:0] XCTL_RESET = 8'h00;
  localparam logic [7:0] XCTL_WMASK = 8'h40;
  // field positions
  localparam int CEIL_LSB = 4;
  localparam int LOW_BIOS_EN_BIT = 3;
  localparam int VGA_EN_BIT = 2;
  localparam int MID_EN_BIT = 1;
  localparam int BIOS_KEEP_BIT = 6;
  localparam int MB_LSB = 20;
  // region bounds
  localparam logic [23:0] MID_LO = 24'h080000;
  localparam logic [23:0] VGA_LO = 24'h0a0000;
  localparam logic [23:0] ROM_LO = 24'h0c0000;
  localparam logic [23:0] LBIOS_LO = 24'h0e0000;
  localparam logic [23:0] UBIOS_LO = 24'h0f0000;
  localparam logic [23:0] EXT_LO = 24'h100000;

  typedef enum logic [2:0] {
    RG_BASE = 3'h0,
    RG_MID = 3'h1,
    RG_VGA = 3'h2,
    RG_ROM = 3'h3,
    RG_LBIOS = 3'h4,
    RG_UBIOS = 3'h5,
    RG_EXT = 3'h6
  } region_t;

  typedef struct packed {
    logic valid;
    logic dma;
    logic [ADDR_W-1:0] addr;
  } cycle_req_t;

  typedef struct packed {
    logic valid;
    logic dma;
    logic forward;
    region_t region;
  } decision_t;
endpackage
`default_nettype wire

//--- hw/fwd_region_decode.sv
`default_nettype none
module fwd_region_decode
  import fwd_pkg::*;
(
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [7:0] ceiling,
  input wire logic bios_keep,
  output logic forward,
  output region_t region
);
  logic below_ceiling;
  logic region_ok;

  always_comb
  begin
    // only the top can be a hole
    below_ceiling = addr[ADDR_W-1:MB_LSB] <= ceiling[7:CEIL_LSB];
    region = RG_EXT;
    region_ok = 1'b1;
    if (addr < MID_LO)
    begin
      region = RG_BASE;
    end
    else if (addr < VGA_LO)
    begin
      region = RG_MID;
      region_ok = ceiling[MID_EN_BIT];
    end
    else if (addr < ROM_LO)
    begin
      region = RG_VGA;
      region_ok = ceiling[VGA_EN_BIT];
    end
    else if (addr < LBIOS_LO)
    begin
      // expansion roms live on isa
      region = RG_ROM;
      region_ok = 1'b0;
    end
    else if (addr < UBIOS_LO)
    begin
      region = RG_LBIOS;
      region_ok = ceiling[LOW_BIOS_EN_BIT] && !bios_keep;
    end
    else if (addr < EXT_LO)
    begin
      region = RG_UBIOS;
    end
    forward = below_ceiling && region_ok;
  end
endmodule
`default_nettype wire

//--- hw/isa_dma_memory_forward_decode.sv
// What this block does
// - bits 7:4 hold ceiling; value n gives n+1 Mbytes.
// - isa/dma memory cycles below ceiling and outside hole go to pci, except c0000-dffff, which always stays on isa.
// - a hole is only recognised as topmost region below 16 Mbytes.
// - bit 3 forwards e0000-effff to pci; clear keeps it on isa.
// - bus chip select bit 6 keeps lower bios on isa always.
// - bit 2 forwards a0000-bffff to pci; clear keeps it on isa.
// - bit 1 forwards 80000-9ffff to pci; clear keeps it on isa.
`default_nettype none
module isa_dma_memory_forward_decode
  import fwd_pkg::*;
#(
  parameter int CNT_W = 16
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire cycle_req_t cycle_req,
  output decision_t decision
);
  if (CNT_W < 1 || CNT_W > 16)
  begin : g_bad_cnt
    $error("CNT_W must lie in 1..16");
  end

  function automatic logic [7:0] reg_index(input logic [PADDR_W-1:0] a);
    return a[PADDR_W-1:2] > 10'h0ff ? 8'h00 : a[9:2];
  endfunction

  function automatic logic mapped(input logic [PADDR_W-1:0] a);
    logic [7:0] i;
    i = reg_index(a);
    return a[PADDR_W-1:10] == '0 && (i == CEIL_IDX || i == XCTL_IDX || i == STAT_IDX);
  endfunction

  logic [7:0] ceiling_reg, ceiling_next;
  logic [7:0] xctl_reg, xctl_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic [CNT_W-1:0] fwd_cnt_reg, fwd_cnt_next;
  logic [CNT_W-1:0] isa_cnt_reg, isa_cnt_next;
  decision_t decision_reg, decision_next;
  logic dec_forward;
  region_t dec_region;
  logic wr_take;
  logic [31:0] status_word;

  fwd_region_decode u_decode (
    .addr(cycle_req.addr),
    .ceiling(ceiling_reg),
    .bios_keep(xctl_reg[BIOS_KEEP_BIT]),
    .forward(dec_forward),
    .region(dec_region)
  );

  always_comb
  begin
    status_word = '0;
    status_word[CNT_W-1:0] = fwd_cnt_reg;
    status_word[16 +: CNT_W] = isa_cnt_reg;
  end

  // apb: answer prepared in setup, ready in the first access cycle
  always_comb
  begin
    pready_next = psel && !penable;
    pslverr_next = 1'b0;
    prdata_next = prdata_reg;
    if (psel && !penable)
    begin
      pslverr_next = !mapped(paddr);
      prdata_next = '0;
      if (!pwrite && mapped(paddr))
      begin
        unique case (reg_index(paddr))
          CEIL_IDX: prdata_next = {24'h000000, ceiling_reg};
          XCTL_IDX: prdata_next = {24'h000000, xctl_reg};
          default: prdata_next = status_word;
        endcase
      end
    end
  end

  assign wr_take = psel && penable && pready_reg && pwrite && !pslverr_reg;

  always_comb
  begin
    ceiling_next = ceiling_reg;
    xctl_next = xctl_reg;
    if (wr_take && reg_index(paddr) == CEIL_IDX)
    begin
      // ceiling field writable; bit 0 reserved
      ceiling_next = pwdata[7:0] & CEIL_WMASK;
    end
    if (wr_take && reg_index(paddr) == XCTL_IDX)
    begin
      xctl_next = pwdata[7:0] & XCTL_WMASK;
    end
  end

  // one-cycle decision; counters wrap, software takes differences
  always_comb
  begin
    decision_next = '0;
    fwd_cnt_next = fwd_cnt_reg;
    isa_cnt_next = isa_cnt_reg;
    if (cycle_req.valid)
    begin
      decision_next.valid = 1'b1;
      decision_next.dma = cycle_req.dma;
      decision_next.forward = dec_forward;
      decision_next.region = dec_region;
      if (dec_forward)
      begin
        fwd_cnt_next = fwd_cnt_reg + 1'b1;
      end
      else
      begin
        isa_cnt_next = isa_cnt_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ceiling_reg <= CEIL_RESET;
      xctl_reg <= XCTL_RESET;
    end
    else
    begin
      ceiling_reg <= ceiling_next;
      xctl_reg <= xctl_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_reg <= '0;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fwd_cnt_reg <= '0;
      isa_cnt_reg <= '0;
      decision_reg <= '0;
    end
    else
    begin
      fwd_cnt_reg <= fwd_cnt_next;
      isa_cnt_reg <= isa_cnt_next;
      decision_reg <= decision_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign decision = decision_reg;
endmodule
`default_nettype wire

//--- testbench/isa_master_model.sv
`default_nettype none
module isa_master_model
  import fwd_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic go,
  input wire logic dma,
  input wire logic [ADDR_W-1:0] addr,
  output var cycle_req_t cycle_req
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle bus inverts address and dma each cycle, valid low; the stale address returns every other idle cycle
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      cycle_req <= '0;
    else if (go)
      cycle_req <= '{1'b1, dma, addr};
    else
      cycle_req <= '{1'b0, ~cycle_req.dma, ~cycle_req.addr};
endmodule
`default_nettype wire

//--- testbench/isa_dma_memory_forward_decode_checker.sv
`default_nettype none
module isa_dma_memory_forward_decode_checker
  import fwd_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire cycle_req_t cycle_req,
  input wire decision_t decision
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_blk(logic [6:0] b);
    cycle_req.valid && cycle_req.addr[23:17] == b;
  endsequence
  a_decide_next: assert property (cycle_req.valid |=> decision.valid)
    else $error("no decision");
  a_no_stray: assert property (!cycle_req.valid |=> !decision.valid)
    else $error("stray decision");
  a_dma_kept: assert property (cycle_req.valid |=> decision.dma == $past(cycle_req.dma))
    else $error("dma lost");
  a_mid_region: assert property (s_blk(7'h04) |=> decision.region == RG_MID)
    else $error("mid region");
  a_vga_region: assert property (s_blk(7'h05) |=> decision.region == RG_VGA)
    else $error("vga region");
  a_rom_kept: assert property (s_blk(7'h06) |=> !decision.forward)
    else $error("rom forwarded");
  a_lbios_region: assert property (s_blk(7'h07) ##0 !cycle_req.addr[16] |=>
    decision.region == RG_LBIOS) else $error("lbios region");
  a_apb_answer: assert property (psel && !penable |=> pready)
    else $error("no pready");
endmodule
bind isa_dma_memory_forward_decode isa_dma_memory_forward_decode_checker chk (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .cycle_req(cycle_req), .decision(decision));
`default_nettype wire

//--- testbench/isa_dma_memory_forward_decode_tb.sv
`default_nettype none
module isa_dma_memory_forward_decode_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import fwd_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, go = 0, dma = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, r;
  logic pready, pslverr, e;
  logic [23:0] addr = '0;
  cycle_req_t cycle_req;
  decision_t decision;
  int err_count = 0, total_checks = 0;
  logic [23:0] tbl [9] = '{24'h07ffff, 24'h080000, 24'h0bffff, 24'h0c0000, 24'h0effff,
    24'h0f0000, 24'h100000, 24'hefffff, 24'hf00000};
  region_t rgn [9] = '{RG_BASE, RG_MID, RG_VGA, RG_ROM, RG_LBIOS, RG_UBIOS, RG_EXT, RG_EXT,
    RG_EXT};
  int fcnt = 0, icnt = 0;
  isa_master_model src (.pclk(pclk), .presetn(presetn), .go(go), .dma(dma), .addr(addr),
    .cycle_req(cycle_req));
  isa_dma_memory_forward_decode DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cycle_req(cycle_req), .decision(decision));
  initial forever #5 pclk = ~pclk;
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    {r, e} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
  endtask
  // ceiling compare is by whole megabyte
  function automatic logic fwd(logic [23:0] a, logic [7:0] c, logic k);
    if (a[23:20] > c[7:4] || a[23:17] == 7'h06)
      return 0;
    if (a[23:18] == 6'h02)
      return c[a[17] ? 2 : 1];
    return a[23:16] == 8'h0e ? c[3] & ~k : 1;
  endfunction
  task automatic run(logic [7:0] c, logic k);
    logic [5:0] got;
    logic f;
    apb(1, 12'h1a4, {24'h0, c});
    apb(1, 12'h1c0, {25'h0, k, 6'h0});
    for (int i = 0; i < 11; i++)
    begin
      @(posedge pclk);
      {go, dma, addr} <= {i < 9, i[0], tbl[i % 9]};
      #1;
      if (i >= 2)
      begin
        got = {decision.valid, decision.dma, decision.forward, decision.region};
        f = fwd(tbl[i - 2], c, k);
        chk(got, {1'b1, i[0], f, rgn[i - 2]});
        if (f)
          fcnt++;
        else
          icnt++;
      end
    end
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    #20000;
    err_count++;
    end_sim;
  end
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1;
    apb(0, 12'h1a4, 0);
    chk(r, 32'h02);
    apb(1, 12'h1a4, 32'hff);
    apb(0, 12'h1a4, 0);
    chk(r, 32'hfe);
    apb(0, 12'h004, 0);
    chk({r[30:0], e}, 32'h1);
    run(8'hee, 0);
    run(8'h00, 0);
    run(8'h08, 1);
    apb(0, 12'h1c0, 0);
    chk(r, 32'h40);
    run(8'hf6, 0);
    apb(0, 12'h1c4, 0);
    chk(r, {icnt[15:0], fcnt[15:0]});
    end_sim;
  end
endmodule
`default_nettype wire
